// ===== logic/alarm_regs_pkg.sv
// Register map, field layout and reset values of the alarm threshold bank.
package alarm_regs_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PRESSURE_TARGET_HIGH = 8'h16;
  localparam logic [7:0] OFS_PRESSURE_TARGET_LOW = 8'h17;
  localparam logic [7:0] OFS_TEMPERATURE_TARGET = 8'h18;
  localparam logic [7:0] OFS_PRESSURE_WINDOW_FIRST = 8'h19;
  localparam logic [7:0] OFS_PRESSURE_WINDOW_SECOND = 8'h1A;
  localparam logic [7:0] OFS_TEMPERATURE_WINDOW = 8'h1B;
  localparam logic [7:0] OFS_MIN_PRESSURE_UPPER = 8'h1C;
  localparam logic [7:0] OFS_MIN_PRESSURE_MIDDLE = 8'h1D;
  localparam logic [7:0] OFS_MIN_PRESSURE_LOWER = 8'h1E;

  // ----------------------------------------------------------------
  // Threshold byte bank: six plain bytes at consecutive offsets
  // ----------------------------------------------------------------
  localparam int THRESH_COUNT = 6;
  localparam int THRESH_IDX_BITS = 3;
  localparam logic [2:0] IDX_PT_HIGH = 3'h0;
  localparam logic [2:0] IDX_PT_LOW = 3'h1;
  localparam logic [2:0] IDX_TT = 3'h2;
  localparam logic [2:0] IDX_PW_FIRST = 3'h3;
  localparam logic [2:0] IDX_PW_SECOND = 3'h4;
  localparam logic [2:0] IDX_TW = 3'h5;

  // ----------------------------------------------------------------
  // Minimum pressure layout
  // ----------------------------------------------------------------
  localparam int MIN_WIDTH = 20;
  localparam int MIN_UPPER_MSB = 19;
  localparam int MIN_UPPER_LSB = 12;
  localparam int MIN_MIDDLE_MSB = 11;
  localparam int MIN_MIDDLE_LSB = 4;
  localparam int MIN_LOWER_MSB = 3;
  localparam int MIN_LOWER_LSB = 0;
  localparam logic [1:0] MIN_SEL_UPPER = 2'h0;
  localparam logic [1:0] MIN_SEL_MIDDLE = 2'h1;
  localparam logic [1:0] MIN_SEL_LOWER = 2'h2;
  localparam logic [3:0] MIN_LOWER_RESERVED = 4'h0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [19:0] RESET_MIN = 20'h00000;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

endpackage

// ===== logic/alarm_threshold_and_min_capture_regs.sv
// Alarm target, window and minimum pressure register bank.
`timescale 1ns/10ps
`default_nettype none
module alarm_threshold_and_min_capture_regs
  import alarm_regs_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic reg_wack_o,
  output logic reg_unmapped_o,
  input wire logic press_sample_valid_i,
  input wire logic [19:0] press_sample_i,
  output logic [15:0] pressure_target_o,
  output logic signed [7:0] temperature_target_o,
  output logic [15:0] pressure_window_o,
  output logic [7:0] temperature_window_o,
  output logic [19:0] min_pressure_o
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Offsets outside the bank leave both hit flags low, so a read
  // returns zero and the unmapped flag pulses instead
  logic thresh_hit;
  logic [2:0] thresh_idx;
  logic min_hit;
  logic [1:0] min_sel;
  logic mapped;

  // Threshold bytes occupy one contiguous run of offsets
  always_comb begin
    thresh_hit = 1'b0;
    thresh_idx = IDX_PT_HIGH;
    min_hit = 1'b0;
    min_sel = MIN_SEL_UPPER;
    case (reg_addr_i)
      OFS_PRESSURE_TARGET_HIGH: begin
        thresh_hit = 1'b1;
        thresh_idx = IDX_PT_HIGH;
      end
      OFS_PRESSURE_TARGET_LOW: begin
        thresh_hit = 1'b1;
        thresh_idx = IDX_PT_LOW;
      end
      OFS_TEMPERATURE_TARGET: begin
        thresh_hit = 1'b1;
        thresh_idx = IDX_TT;
      end
      OFS_PRESSURE_WINDOW_FIRST: begin
        thresh_hit = 1'b1;
        thresh_idx = IDX_PW_FIRST;
      end
      OFS_PRESSURE_WINDOW_SECOND: begin
        thresh_hit = 1'b1;
        thresh_idx = IDX_PW_SECOND;
      end
      OFS_TEMPERATURE_WINDOW: begin
        thresh_hit = 1'b1;
        thresh_idx = IDX_TW;
      end
      OFS_MIN_PRESSURE_UPPER: begin
        min_hit = 1'b1;
        min_sel = MIN_SEL_UPPER;
      end
      OFS_MIN_PRESSURE_MIDDLE: begin
        min_hit = 1'b1;
        min_sel = MIN_SEL_MIDDLE;
      end
      OFS_MIN_PRESSURE_LOWER: begin
        min_hit = 1'b1;
        min_sel = MIN_SEL_LOWER;
      end
      default: begin
        thresh_hit = 1'b0;
        min_hit = 1'b0;
      end
    endcase
  end

  // Either hit means this bank owns the offset
  assign mapped = thresh_hit | min_hit;

  // ----------------------------------------------------------------
  // Threshold byte storage
  // ----------------------------------------------------------------
  logic [7:0] thresh_byte [THRESH_COUNT];

  // One plain read/write byte per entry, cleared at reset
  // Each entry matches the decoded index against its own position
  generate
    for (genvar g = 0; g < THRESH_COUNT; g++) begin : g_thresh
      always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          thresh_byte[g] <= RESET_BYTE;
        end else if (reg_wr_i && thresh_hit && (thresh_idx == THRESH_IDX_BITS'(g))) begin
          thresh_byte[g] <= reg_wdata_i;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Exported threshold values
  // ----------------------------------------------------------------
  // No latching across byte pairs: between two host writes of one
  // 16-bit value the comparator briefly sees a half-updated value
  // Target high byte at the lower offset, low byte at the next
  assign pressure_target_o = {thresh_byte[IDX_PT_HIGH], thresh_byte[IDX_PT_LOW]};
  // Signed view lets the comparator handle sub-zero targets directly
  assign temperature_target_o = $signed(thresh_byte[IDX_TT]);
  // Window first byte carries the upper eight bits
  assign pressure_window_o = {thresh_byte[IDX_PW_FIRST], thresh_byte[IDX_PW_SECOND]};
  assign temperature_window_o = thresh_byte[IDX_TW];

  // ----------------------------------------------------------------
  // Minimum pressure capture
  // ----------------------------------------------------------------
  logic [19:0] min_value;
  logic min_wr;

  // Host writes reach the store only for the three minimum offsets
  assign min_wr = reg_wr_i && min_hit;

  // A sample that is taken and a host write in one cycle: the sample is kept
  min_pressure_track min_pressure_track_inst (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .sample_valid_i(press_sample_valid_i),
    .sample_i(press_sample_i),
    .host_wr_i(min_wr),
    .host_sel_i(min_sel),
    .host_data_i(reg_wdata_i),
    .min_o(min_value)
  );

  assign min_pressure_o = min_value;

  // ----------------------------------------------------------------
  // Read data select
  // ----------------------------------------------------------------
  logic [7:0] read_mux;

  // Reserved nibble of the lower minimum byte is forced to zero
  // A read with a write in the same cycle sees the byte before the write
  always_comb begin
    read_mux = READ_UNMAPPED;
    if (thresh_hit) begin
      read_mux = thresh_byte[thresh_idx];
    end else if (min_hit) begin
      case (min_sel)
        MIN_SEL_UPPER: read_mux = min_value[MIN_UPPER_MSB:MIN_UPPER_LSB];
        MIN_SEL_MIDDLE: read_mux = min_value[MIN_MIDDLE_MSB:MIN_MIDDLE_LSB];
        MIN_SEL_LOWER: read_mux = {min_value[MIN_LOWER_MSB:MIN_LOWER_LSB], MIN_LOWER_RESERVED};
        default: read_mux = READ_UNMAPPED;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data register
  // ----------------------------------------------------------------
  // Registered so the serial engine sees a stable byte one cycle later
  // Byte stands until the next read strobe, so a slow engine may fetch it late
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= RESET_BYTE;
    end else if (reg_rd_i) begin
      reg_rdata_o <= read_mux;
    end
  end

  // Read strobe echoed as a one-cycle valid
  // Issued for unmapped offsets too, so every read gets an answer
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // ----------------------------------------------------------------
  // Access status
  // ----------------------------------------------------------------
  // Write acknowledge, one cycle after the strobe, mapped or not
  // Acknowledging refused writes keeps the serial engine from stalling
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_wack_o <= 1'b0;
    end else begin
      reg_wack_o <= reg_wr_i;
    end
  end

  // Flags an access to an offset this bank does not own
  // Registered like the other answers so all of them line up in one cycle
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_unmapped_o <= 1'b0;
    end else begin
      reg_unmapped_o <= (reg_wr_i | reg_rd_i) & ~mapped;
    end
  end

endmodule
`default_nettype wire

// ===== logic/min_pressure_track.sv
// Minimum pressure capture store with host byte writes.
`timescale 1ns/10ps
`default_nettype none
module min_pressure_track
  import alarm_regs_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic sample_valid_i,
  input wire logic [19:0] sample_i,
  input wire logic host_wr_i,
  input wire logic [1:0] host_sel_i,
  input wire logic [7:0] host_data_i,
  output logic [19:0] min_o
);

  // ----------------------------------------------------------------
  // Capture decision
  // ----------------------------------------------------------------
  logic [19:0] min_value;
  logic take_sample;
  logic [19:0] next_written;

  // A zero store means empty, so the first sample after a clear loads
  assign take_sample = sample_valid_i && ((min_value == RESET_MIN) || (sample_i < min_value));

  // Host byte merged into the stored value; low nibble of the lower byte is dropped
  always_comb begin
    next_written = min_value;
    case (host_sel_i)
      MIN_SEL_UPPER: next_written[MIN_UPPER_MSB:MIN_UPPER_LSB] = host_data_i;
      MIN_SEL_MIDDLE: next_written[MIN_MIDDLE_MSB:MIN_MIDDLE_LSB] = host_data_i;
      MIN_SEL_LOWER: next_written[MIN_LOWER_MSB:MIN_LOWER_LSB] = host_data_i[7:4];
      default: next_written = min_value;
    endcase
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Capture wins over a host write in the same cycle so no sample is lost
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      min_value <= RESET_MIN;
    end else if (take_sample) begin
      min_value <= sample_i;
    end else if (host_wr_i) begin
      min_value <= next_written;
    end
  end

  assign min_o = min_value;

endmodule
`default_nettype wire

// ===== verif/alarm_regs_asserts.sv
// Port-level assertions for the alarm threshold and minimum capture bank.
`timescale 1ns/10ps
`default_nettype none
module alarm_regs_asserts
  import alarm_regs_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic reg_wack_o,
  input wire logic reg_unmapped_o,
  input wire logic press_sample_valid_i,
  input wire logic [19:0] press_sample_i,
  input wire logic [15:0] pressure_target_o,
  input wire logic signed [7:0] temperature_target_o,
  input wire logic [15:0] pressure_window_o,
  input wire logic [7:0] temperature_window_o,
  input wire logic [19:0] min_pressure_o
);
  // ----
  // Checks
  // ----
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic hit;
  // Offset inside the bank
  assign hit = (reg_addr_i >= 8'h16) && (reg_addr_i <= 8'h1E);
  a_write_ack: assert property (reg_wr_i |=> reg_wack_o)
    else $error("write not acknowledged");
  a_read_valid: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  a_unmapped_read: assert property (reg_rd_i && !hit |=> reg_unmapped_o && reg_rdata_o == 8'h00)
    else $error("unmapped read wrong");
  a_target_low: assert property (reg_wr_i && reg_addr_i == 8'h17 |=> pressure_target_o[7:0] == $past(reg_wdata_i))
    else $error("target low byte wrong");
  a_window_order: assert property (reg_wr_i && reg_addr_i == 8'h19 |=> pressure_window_o[15:8] == $past(reg_wdata_i))
    else $error("window upper byte wrong");
  a_temp_readback: assert property (reg_rd_i && reg_addr_i == 8'h18 |=> reg_rdata_o == $past(temperature_target_o))
    else $error("temperature target readback wrong");
  a_low_nibble: assert property (reg_rd_i && reg_addr_i == 8'h1E |=> reg_rdata_o[3:0] == 4'h0)
    else $error("reserved nibble not zero");
  a_min_lower: assert property (reg_rd_i && reg_addr_i == 8'h1E |=> reg_rdata_o[7:4] == $past(min_pressure_o[3:0]))
    else $error("lower minimum byte readback wrong");
  a_min_capture: assert property (press_sample_valid_i && (min_pressure_o == 20'h0 || press_sample_i < min_pressure_o) |=> min_pressure_o == $past(press_sample_i))
    else $error("minimum not captured");
  a_min_hold: assert property (!press_sample_valid_i && !reg_wr_i |=> $stable(min_pressure_o))
    else $error("minimum changed unprompted");
  a_min_middle: assert property (reg_wr_i && reg_addr_i == 8'h1D && !press_sample_valid_i |=> min_pressure_o[11:4] == $past(reg_wdata_i))
    else $error("middle byte write lost");
  c_lower_sample: cover property (press_sample_valid_i && min_pressure_o != 20'h0 && press_sample_i < min_pressure_o);
  c_unmapped: cover property (reg_rd_i && !hit);
  c_lower_write: cover property (reg_wr_i && reg_addr_i == 8'h1E);
endmodule
bind alarm_threshold_and_min_capture_regs alarm_regs_asserts alarm_regs_asserts_inst (
  .mclk_i(mclk_i),
  .rst_i(rst_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o),
  .reg_wack_o(reg_wack_o),
  .reg_unmapped_o(reg_unmapped_o),
  .press_sample_valid_i(press_sample_valid_i),
  .press_sample_i(press_sample_i),
  .pressure_target_o(pressure_target_o),
  .temperature_target_o(temperature_target_o),
  .pressure_window_o(pressure_window_o),
  .temperature_window_o(temperature_window_o),
  .min_pressure_o(min_pressure_o)
);
`default_nettype wire

// ===== verif/alarm_threshold_and_min_capture_regs_tb.sv
// Self-checking bench for the alarm threshold and minimum capture bank.
`timescale 1ns/10ps
`default_nettype none
module alarm_threshold_and_min_capture_regs_tb;
  import alarm_regs_pkg::*;
  logic mclk_i, rst_i, reg_wr_i, reg_rd_i, reg_rvalid_o, reg_wack_o, reg_unmapped_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, temperature_window_o, q;
  logic press_sample_valid_i, ack, unm;
  logic [19:0] press_sample_i, min_pressure_o;
  logic [15:0] pressure_target_o, pressure_window_o;
  logic signed [7:0] temperature_target_o;
  int err_total, n_compared;
  alarm_threshold_and_min_capture_regs alarm_threshold_and_min_capture_regs_inst (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o),
    .reg_wack_o(reg_wack_o),
    .reg_unmapped_o(reg_unmapped_o),
    .press_sample_valid_i(press_sample_valid_i),
    .press_sample_i(press_sample_i),
    .pressure_target_o(pressure_target_o),
    .temperature_target_o(temperature_target_o),
    .pressure_window_o(pressure_window_o),
    .temperature_window_o(temperature_window_o),
    .min_pressure_o(min_pressure_o)
  );
  reg_host_model reg_host_model_inst (.mclk_i(mclk_i), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o), .reg_wack_i(reg_wack_o),
    .reg_unmapped_i(reg_unmapped_o));
  // ----
  // Tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d, input logic bad);
    reg_host_model_inst.access(1'b1, a, d, q, ack, unm);
    check({ack, unm}, {1'b1, bad});
  endtask
  task automatic rd8(input logic [7:0] a, input logic [7:0] e, input logic bad);
    reg_host_model_inst.access(1'b0, a, 8'h00, q, ack, unm);
    check({q, ack, unm}, {e, 1'b1, bad});
  endtask
  task automatic sample(input logic [19:0] s);
    @(posedge mclk_i);
    #1;
    press_sample_valid_i = 1'b1;
    press_sample_i = s;
    @(posedge mclk_i);
    #1;
    press_sample_valid_i = 1'b0;
    press_sample_i = ~s;
  endtask
  // Every bank byte reads zero; a fresh bank is also the empty minimum
  task automatic zeros();
    for (int i = 0; i < 9; i++) begin
      rd8(8'h16 + 8'(i), 8'h00, 1'b0);
    end
  endtask
  // Distinct byte per offset, 0x18 negative
  function automatic logic [7:0] pat(input int i);
    return 8'h96 + 8'h11 * 8'(i);
  endfunction
  // ----
  // Clock, watchdog, sequence
  // ----
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  initial begin
    #500000;
    err_total++;
    final_report();
  end
  initial begin
    err_total = 0;
    n_compared = 0;
    press_sample_valid_i = 1'b0;
    press_sample_i = 20'h00000;
    rst_i = 1'b1;
    repeat (4) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    zeros();
    for (int i = 0; i < 9; i++) begin
      wr8(8'h16 + 8'(i), pat(i), 1'b0);
    end
    for (int i = 0; i < 9; i++) begin
      rd8(8'h16 + 8'(i), (i == 8) ? 8'h10 : pat(i), 1'b0);
    end
    check(pressure_target_o, 16'h96A7);
    check({31'h0, temperature_target_o < 8'sh00}, 32'h1);
    check({24'h000000, temperature_target_o}, 32'h000000B8);
    check(pressure_window_o, 16'hC9DA);
    check(temperature_window_o, 8'hEB);
    check(min_pressure_o, 20'hFC0D1);
    wr8(8'h15, 8'h55, 1'b1);
    rd8(8'h15, 8'h00, 1'b1);
    rd8(8'h1F, 8'h00, 1'b1);
    for (int i = 0; i < 3; i++) begin
      wr8(8'h1C + 8'(i), 8'h00, 1'b0);
    end
    sample(20'h12345);
    check(min_pressure_o, 20'h12345);
    sample(20'h23456);
    check(min_pressure_o, 20'h12345);
    sample(20'h0ABCD);
    check(min_pressure_o, 20'h0ABCD);
    rd8(8'h1C, 8'h0A, 1'b0);
    rd8(8'h1D, 8'hBC, 1'b0);
    rd8(8'h1E, 8'hD0, 1'b0);
    @(posedge mclk_i);
    #1;
    rst_i = 1'b1;
    @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    zeros();
    final_report();
  end
endmodule
`default_nettype wire

// ===== verif/reg_host_model.sv
// Host side of the register port: one-cycle strobes, answer taken next edge.
`timescale 1ns/10ps
`default_nettype none
module reg_host_model (
  input wire logic mclk_i,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i,
  input wire logic reg_wack_i,
  input wire logic reg_unmapped_i
);
  // ----
  // Bus cycle
  // ----
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end
  // Released lines show the inverse, so a stale value never passes
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ack, output logic unm);
    @(posedge mclk_i);
    #1;
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = wr;
    reg_rd_o = !wr;
    @(posedge mclk_i);
    #1;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
    q = reg_rdata_i;
    ack = wr ? reg_wack_i : reg_rvalid_i;
    unm = reg_unmapped_i;
  endtask
endmodule
`default_nettype wire
